// >>> hdl/change_detect.sv
// Mismatch detector for the upper four pins.
// Assumes pins are synchronous to aclk; refresh marks a port access.
`timescale 1ns/1ns
module change_detect
  import port_change_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to the port block
  change_if.detector cif
);

  logic [CHG_W-1:0] snap_reg;
  logic primed_reg;
  logic mismatch_reg;

  assign cif.mismatch = mismatch_reg;

  // Load the copy once after reset so stale levels raise nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed_reg <= 1'b0;
    end else begin
      primed_reg <= 1'b1;
    end
  end

  // Copy of pin levels taken at every port access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_reg <= 4'h0;
    end else if (cif.refresh || !primed_reg) begin
      snap_reg <= cif.pins;
    end
  end

  // A change landing on the access cycle is absorbed, not flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mismatch_reg <= 1'b0;
    end else if (cif.refresh || !primed_reg) begin
      mismatch_reg <= 1'b0;
    end else begin
      mismatch_reg <= |((cif.pins ^ snap_reg) & cif.input_mask);
    end
  end

endmodule // change_detect

// >>> hdl/change_if.sv
// Carrier between the port block and its change detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface change_if;
  logic [3:0] pins;
  logic [3:0] input_mask;
  logic refresh;
  logic mismatch;

  modport detector (input pins, input input_mask, input refresh, output mismatch);
  modport port (output pins, output input_mask, output refresh, input mismatch);
endinterface

// >>> hdl/port_change_irq_port.sv
// 8-bit bidirectional port with weak pull-ups, change detection and interrupt control.
// Assumes an AXI4-Lite master on aclk and pin inputs already synchronous to aclk.
//
// Operation
// - Interrupt control register is read/write and appears at all mirrored addresses.
// - Flags set on their events regardless of own or global enable.
// - Bit 7 is the global enable; cleared blocks every interrupt request.
// - Bit 4 enables the external pin interrupt; its flag sets anyway.
// - Bit 3 enables the port change interrupt.
// - Direction one floats the pin; zero drives the output latch.
// - An enabled alternate function owns the pin, ignoring direction.
// - Port reads return pin levels; port writes update only the latch.
// - Port writes are read-modify-write: pins sampled, modified, stored.
// - One active-low option bit turns on all eight pull-ups.
// - A pin set as output has its pull-up switched off.
// - Reset leaves all pull-ups disabled.
// - Only upper four pins, and only inputs, join change detection.
// - Inputs compare with a copy taken at the last port access.
// - Mismatches are ORed to set the port change flag at bit 0.
// - A port change interrupt can wake the device from sleep.
// - Any port read or write refreshes the copy, ending the mismatch.
// - A lasting mismatch keeps setting the flag; software accesses port first.
// - A change during the access cycle may be absorbed unflagged.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module port_change_irq_port
  import port_change_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pullup_en,
  // Alternate functions
  input wire logic [7:0] alt_enable,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe,
  // Event sources and core side
  input wire logic timer_overflow,
  input wire logic periph_irq_pending,
  output logic irq_out,
  output logic wake_out
);

  // Map a byte address onto a register; bits [1:0] are ignored
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2];
    if (idx == IDX_CTRL_BANK0 || idx == IDX_CTRL_BANK1 ||
        idx == IDX_CTRL_BANK2 || idx == IDX_CTRL_BANK3) begin
      return SEL_CTRL;
    end else if (idx == IDX_PORT_DATA) begin
      return SEL_DATA;
    end else if (idx == IDX_PORT_DIR) begin
      return SEL_DIR;
    end else if (idx == IDX_OPTION) begin
      return SEL_OPT;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // Registers
  logic [7:0] ctrl_reg;
  logic [7:0] latch_reg;
  logic [7:0] dir_reg;
  logic [7:0] option_reg;

  // Bus state
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rdata_reg;

  // Pin and event state
  logic [7:0] pin_out_reg;
  logic [7:0] pin_oe_reg;
  logic [7:0] pullup_reg;
  logic ext_prev_reg;
  logic primed_reg;
  logic irq_reg;
  logic wake_reg;

  // Decoded strobes
  logic wr_fire;
  logic rd_fire;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic wr_ctrl;
  logic port_access;
  logic ext_event;
  logic [7:0] ctrl_next;

  change_if cif ();

  change_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .cif(cif)
  );

  // Output ports straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign pullup_en = pullup_reg;
  assign irq_out = irq_reg;
  assign wake_out = wake_reg;

  // Write commits once both halves are held
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && arready_reg;
  assign wr_sel = decode(awaddr_reg);
  assign rd_sel = decode(s_axi_araddr);
  assign wr_ctrl = wr_fire && wstrb0_reg && (wr_sel == SEL_CTRL);
  // Every read or write of the port data refreshes the comparison copy
  assign port_access = (wr_fire && wr_sel == SEL_DATA) ||
                       (rd_fire && rd_sel == SEL_DATA);

  // Detector link: inputs among the upper pins only
  assign cif.pins = pin_in[CHG_LO +: CHG_W];
  assign cif.input_mask = dir_reg[CHG_LO +: CHG_W] &
                          ~alt_enable[CHG_LO +: CHG_W];
  assign cif.refresh = port_access;

  // Write address channel; held until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      awaddr_reg <= 12'h000;
    end else if (s_axi_awvalid && awready_reg) begin
      aw_full_reg <= 1'b1;
      awready_reg <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (bvalid_reg && s_axi_bready) begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b1;
    end
  end

  // Write data channel; only lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b1;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && wready_reg) begin
      w_full_reg <= 1'b1;
      wready_reg <= 1'b0;
      wdata_reg <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (bvalid_reg && s_axi_bready) begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; one read in flight, data one edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 8'h00;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rd_sel)
        SEL_CTRL: rdata_reg <= ctrl_reg;
        SEL_DATA: rdata_reg <= pin_in;
        SEL_DIR: rdata_reg <= dir_reg;
        SEL_OPT: rdata_reg <= option_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Output latch: pins are sampled, then lane 0 modifies them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= LATCH_RESET;
    end else if (wr_fire && wr_sel == SEL_DATA) begin
      latch_reg <= wstrb0_reg ? wdata_reg : pin_in;
    end
  end

  // Direction register; all inputs after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg <= DIR_RESET;
    end else if (wr_fire && wstrb0_reg && wr_sel == SEL_DIR) begin
      dir_reg <= wdata_reg;
    end
  end

  // Option register; pull-up-off bit resets high so pull-ups start off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_reg <= OPTION_RESET;
    end else if (wr_fire && wstrb0_reg && wr_sel == SEL_OPT) begin
      option_reg <= wdata_reg;
    end
  end

  // Hold off edge detection for one cycle after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed_reg <= 1'b0;
    end else begin
      primed_reg <= 1'b1;
    end
  end

  // External pin edge, polarity from the option register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= pin_in[0];
    end
  end

  assign ext_event = primed_reg && (option_reg[EDGE_RISE_BIT] ?
                     (pin_in[0] && !ext_prev_reg) : (!pin_in[0] && ext_prev_reg));

  // Flags: software write first, then hardware sets win over a clear
  always_comb begin
    ctrl_next = wr_ctrl ? wdata_reg : ctrl_reg;
    if (timer_overflow) begin
      ctrl_next[TIMER_FLAG_BIT] = 1'b1;
    end
    if (ext_event) begin
      ctrl_next[EXT_FLAG_BIT] = 1'b1;
    end
    // A lasting mismatch re-sets the flag every cycle until the port is accessed
    if (cif.mismatch) begin
      ctrl_next[CHANGE_FLAG_BIT] = 1'b1;
    end
  end

  // Interrupt control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Request to the core, one cycle behind the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ctrl_reg[GLOBAL_EN_BIT] && (
        (ctrl_reg[TIMER_EN_BIT] && ctrl_reg[TIMER_FLAG_BIT]) ||
        (ctrl_reg[EXT_EN_BIT] && ctrl_reg[EXT_FLAG_BIT]) ||
        (ctrl_reg[CHANGE_EN_BIT] && ctrl_reg[CHANGE_FLAG_BIT]) ||
        (ctrl_reg[PERIPH_EN_BIT] && periph_irq_pending));
    end
  end

  // Wake ignores the global enable so sleep ends even with interrupts off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= (ctrl_reg[CHANGE_EN_BIT] && ctrl_reg[CHANGE_FLAG_BIT]) ||
                  (ctrl_reg[EXT_EN_BIT] && ctrl_reg[EXT_FLAG_BIT]);
    end
  end

  // Per-pin driver, enable and pull-up
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_out_reg[i] <= 1'b0;
          pin_oe_reg[i] <= 1'b0;
          pullup_reg[i] <= 1'b0;
        end else begin
          pin_out_reg[i] <= alt_enable[i] ? alt_out[i] : latch_reg[i];
          pin_oe_reg[i] <= alt_enable[i] ? alt_oe[i] : !dir_reg[i];
          // Driven pins never pull up, whatever the global bit says
          pullup_reg[i] <= !option_reg[PULLUP_OFF_BIT] &&
                           !(alt_enable[i] ? alt_oe[i] : !dir_reg[i]);
        end
      end
    end
  endgenerate

endmodule // port_change_irq_port

// >>> hdl/port_change_pkg.sv
// Constants for the 8-bit port with change detection and interrupt control.
// Assumes a 32-bit AXI4-Lite register bus, one byte register per word.
package port_change_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_CTRL_BANK0 = 10'h00B;
  localparam logic [9:0] IDX_CTRL_BANK1 = 10'h08B;
  localparam logic [9:0] IDX_CTRL_BANK2 = 10'h10B;
  localparam logic [9:0] IDX_CTRL_BANK3 = 10'h18B;
  localparam logic [9:0] IDX_PORT_DATA = 10'h006;
  localparam logic [9:0] IDX_PORT_DIR = 10'h086;
  localparam logic [9:0] IDX_OPTION = 10'h081;

  // interrupt_control bit positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int TIMER_EN_BIT = 5;
  localparam int EXT_EN_BIT = 4;
  localparam int CHANGE_EN_BIT = 3;
  localparam int TIMER_FLAG_BIT = 2;
  localparam int EXT_FLAG_BIT = 1;
  localparam int CHANGE_FLAG_BIT = 0;

  // option bit positions
  localparam int PULLUP_OFF_BIT = 7;
  localparam int EDGE_RISE_BIT = 6;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;

  // Change detection covers the upper four pins
  localparam int CHG_LO = 4;
  localparam int CHG_W = 4;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_DATA = 3'b010,
    SEL_DIR = 3'b011,
    SEL_OPT = 3'b100
  } reg_sel_t;

endpackage

// >>> sim/pin_partner.sv
// Keypad and board model resolving the eight pin levels.
// Assumes the port samples pin_in on aclk.
`timescale 1ns/1ns
module pin_partner (
  // Clock
  input wire logic aclk,
  // Port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  // Keys or board drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved levels
  output logic [7:0] pin_in
);
  logic flt = 1'h0;
  // Undriven pins wander so no level is assumed
  always_ff @(posedge aclk) begin
    flt <= ~flt;
  end
  // Port driver wins, then keys, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'h1;
      else pin_in[i] = flt ^ i[0];
    end
  end
endmodule // pin_partner

// >>> sim/port_change_monitor.sv
// Assertions on the top ports of the port block.
// Assumes one clock domain and a bind by name from the bench.
`timescale 1ns/1ns
module port_change_monitor
  import port_change_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and alternate functions
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] alt_enable,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Pull-up must never fight a driven pin
  pullup_driven_a: assert property (!(|(pullup_en & pin_oe)))
    else $error("pull-up on while pin driven");
  pullup_reset_a: assert property (!$past(aresetn) |-> pullup_en == 8'h00)
    else $error("pull-up on after reset");
  // Alternate function owns enabled pins one edge later
  alt_oe_a: assert property ($past(aresetn) |->
    ((pin_oe ^ $past(alt_oe)) & $past(alt_enable)) == 8'h00)
    else $error("alternate enable not followed");
  alt_out_a: assert property ($past(aresetn) |->
    ((pin_out ^ $past(alt_out)) & $past(alt_enable & alt_oe)) == 8'h00)
    else $error("alternate output not followed");
  // Answers stand until taken
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next edge");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
endmodule // port_change_monitor

// >>> sim/tb.sv
// Self-checking bench for the port block and its pin partner.
// Assumes the package and detector are compiled first.
`timescale 1ns/1ns
module tb
  import port_change_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, timer_overflow = 0, periph_irq_pending = 0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [7:0] alt_enable = '0, alt_out = '0, alt_oe = '0, ext_en = 8'hFF, ext_val = 8'hFF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_out, wake_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pin_in, pin_out, pin_oe, pullup_en;
  logic [1:0] bq[$], pq[$];
  logic [31:0] rq[$];
  logic [31:0] rs = 32'h29, rv;
  int error_cnt = 0, checks_done = 0;
  localparam logic [11:0] A_D = {IDX_PORT_DATA, 2'h0}, A_R = {IDX_PORT_DIR, 2'h0};
  localparam logic [11:0] A_O = {IDX_OPTION, 2'h0}, A_X = 12'h100;
  logic [11:0] cb [4] = '{{IDX_CTRL_BANK0, 2'h0}, {IDX_CTRL_BANK1, 2'h0},
    {IDX_CTRL_BANK2, 2'h0}, {IDX_CTRL_BANK3, 2'h0}};
  logic [7:0] ce [5] = '{8'hA0, 8'h20, 8'hC0, 8'h80, 8'h90};
  logic ie [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};

  port_change_irq_port dut (.*);
  pin_partner keys (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // Free-running clock
  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] r);
    logic [31:0] t;
    bq.push_back(r);
    t = rnd();
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {t[31:8], d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rq.push_back({24'h000000, e});
    pq.push_back((a == A_X) ? RESP_SLVERR : RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  // Results matched against the oldest note as they appear
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk("rdata", s_axi_rdata, rq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk("rresp", s_axi_rresp, pq.pop_front());
  end

  // Hang guard, well beyond the sequence length
  initial begin
    cyc(20000);
    error_cnt++;
    final_report();
  end

  // Main sequence; board holds pins high until pull-ups are on
  initial begin
    cyc(2);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("pullup", pullup_en, 8'h00);
    foreach (cb[i]) rd(cb[i], 8'h00);
    rd(A_R, 8'hFF);
    wr(A_X, 8'h5A, 4'hF, RESP_SLVERR);
    rd(A_X, 8'h00);
    wr(A_O, 8'h7F, 4'hF, RESP_OKAY);
    ext_en <= 8'h00;
    cyc(2);
    chk("pullup", pullup_en, 8'hFF);
    // Lower four pins become outputs, upper four stay inputs
    wr(A_R, 8'hF0, 4'hF, RESP_OKAY);
    wr(A_D, 8'hA5, 4'hF, RESP_OKAY);
    cyc(2);
    chk("oe", pin_oe, 8'h0F);
    chk("out", pin_out & 8'h0F, 8'h05);
    chk("pullup", pullup_en, 8'hF0);
    rd(A_D, 8'hF5);
    rv = rnd();
    ext_val <= rv[7:0];
    ext_en <= 8'hF0;
    // Empty strobe still reloads the latch from the pins
    wr(A_D, 8'h00, 4'h0, RESP_OKAY);
    wr(A_R, 8'h00, 4'hF, RESP_OKAY);
    cyc(2);
    chk("out", pin_out, {rv[7:4], 4'h5});
    ext_en <= 8'h00;
    wr(A_R, 8'hFF, 4'hF, RESP_OKAY);
    rd(A_D, 8'hFF);
    wr(cb[1], 8'h88, 4'hF, RESP_OKAY);
    cyc(3);
    chk("irq", irq_out, 1'h0);
    ext_val <= 8'h00;
    // Key press lands while software leaves the port unpolled
    ext_en <= 8'h80;
    cyc(4);
    chk("irq", irq_out, 1'h1);
    chk("wake", wake_out, 1'h1);
    rd(cb[2], 8'h89);
    wr(cb[3], 8'h88, 4'hF, RESP_OKAY);
    rd(cb[0], 8'h89);
    rd(A_D, 8'h7F);
    wr(cb[0], 8'h88, 4'hF, RESP_OKAY);
    rd(cb[0], 8'h88);
    ext_en <= 8'h88;
    cyc(4);
    rd(cb[0], 8'h88);
    // Timer, peripheral and edge sources under each enable
    for (int k = 0; k < 5; k++) begin
      wr(cb[k % 4], ce[k], 4'hF, RESP_OKAY);
      timer_overflow <= (k < 2);
      periph_irq_pending <= (k == 2 || k == 3);
      ext_en <= (k == 4) ? 8'h89 : 8'h88;
      @(posedge aclk);
      timer_overflow <= 1'h0;
      ext_en <= 8'h88;
      cyc(5);
      chk("irq", irq_out, ie[k]);
      periph_irq_pending <= 1'h0;
    end
    repeat (4) begin
      rv = rnd();
      alt_enable <= rv[7:0];
      alt_out <= rv[15:8];
      alt_oe <= rv[23:16];
      cyc(2);
      chk("alt oe", pin_oe & rv[7:0], rv[23:16] & rv[7:0]);
    end
    final_report();
  end
endmodule // tb

bind port_change_irq_port port_change_monitor mon (.*);
